// ==== design/ise_slave.sv ====
`timescale 1ns/1ps
// What this block does
// R1 - 512 EEPROM bytes: two 256-byte blocks, 32 pages of 8 each.
// R2 - Pages start on multiples of 8 word addresses.
// R3 - Page write past the page end wraps to that page's first byte.
// R4 - Host avoids page writes that cross a page end.
// R5 - Slave only; works with SCL up to 100 kHz and 400 kHz.
// R6 - SDA falling while SCL high is START; start accepted in any state.
// R7 - SDA rising while SCL high is STOP, ending the transfer.
// R8 - SDA stable while SCL high; one SCL pulse per bit.
// R9 - Bytes are 8 bits MSB first, ninth clock carries acknowledge.
// R10 - No acknowledge to EEPROM access during a programming cycle.
// R11 - Acknowledger holds SDA low through the ninth clock high phase.
// R12 - Master NACKs last read byte; slave then releases SDA.
// R13 - Transfer ends with STOP or repeated START.
// R14 - Answer only address bytes 1101 with top block-select bit 0.
// R15 - Block-select bits are the top three word address bits.
// R16 - Address byte LSB: 1 read, 0 write.
// R17 - Write: word address loads pointer, then data bytes, then STOP.
// R18 - Write cycle starts at STOP; EEPROM NACKs until it completes.
// R19 - Up to 8 bytes buffered, committed after STOP, others unchanged.
// R20 - More than 8 bytes roll over within the page buffer.
// R21 - Pointer advances by one per accepted data byte.
// R22 - Block 0 writes ignore page limit, wrap in block, commit at STOP.
// R23 - Block 000 clock, 001 lower EEPROM, 010 upper EEPROM.
// R24 - Polling address gets NACK while busy, ACK when done.
// R25 - Clock block stays reachable during an EEPROM write cycle.
// R26 - Unmatched address: no ACK, ignore bus until next START.
// R27 - SCL and SDA synchronised before START, STOP and edges detected.
`include "ise_params.svh"

module ise_slave
    import ise_pkg::*;
#(
    parameter int MCLK_HZ = 25000000
) (
    // Clock and reset
    input  logic        mclk,
    input  logic        rst,
    // Two-wire bus
    input  logic        scl_in,
    input  logic        sda_in,
    output logic        sda_out,
    output logic        sda_oe,
    // EEPROM core
    input  logic        ee_done,
    output ise_ee_cmd_t ee_cmd,
    output logic        ee_busy,
    // Clock register core
    output ise_rtc_wr_t rtc_wr,
    output logic        rtc_commit,
    output logic [7:0]  word_ptr
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    localparam int SCL_HALF_CYC = MCLK_HZ / (2 * `ISE_SCL_FAST_HZ);

    generate
        if (SCL_HALF_CYC < `ISE_MIN_HALF_CYC) begin : g_bad_clk  // R5
            $error("mclk too slow for fast-mode SCL");
        end
        if (`ISE_PAGE_BYTES * `ISE_BLOCK_PAGES != `ISE_BLOCK_BYTES)
        begin : g_bad_map
            $error("page map does not fill a block");
        end
    endgenerate

    // ************************************************************
    // Decoding helpers
    // ************************************************************
    function automatic logic is_ee(input logic [2:0] blk);
        is_ee = (blk == `ISE_BLK_EE_LO) || (blk == `ISE_BLK_EE_HI);
    endfunction

    function automatic logic blk_ok(input logic [2:0] blk);
        blk_ok = (blk == `ISE_BLK_RTC) || is_ee(blk);
    endfunction

    // ************************************************************
    // Line synchronisers, index 1 is SCL, index 0 is SDA
    // ************************************************************
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] sync3_r;
    logic [1:0] line_r;
    logic [1:0] line_prev_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_r <= `ISE_LINE_IDLE;
            sync2_r <= `ISE_LINE_IDLE;
            sync3_r <= `ISE_LINE_IDLE;
        end else begin
            sync1_r <= {scl_in, sda_in};  // R27
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    line_r[gi] <= 1'b1;
                end else if (sync2_r[gi] == sync3_r[gi]) begin
                    line_r[gi] <= sync3_r[gi];  // R27
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            line_prev_r <= `ISE_LINE_IDLE;
        end else begin
            line_prev_r <= line_r;
        end
    end

    // ************************************************************
    // Bus conditions
    // ************************************************************
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_rise   = line_r[1] && !line_prev_r[1];
    assign scl_fall   = !line_r[1] && line_prev_r[1];
    assign start_cond = line_r[1] && line_prev_r[1]
                        && line_prev_r[0] && !line_r[0];  // R6 R13
    assign stop_cond  = line_r[1] && line_prev_r[1]
                        && !line_prev_r[0] && line_r[0];  // R7 R13

    // ************************************************************
    // Byte receiver state
    // ************************************************************
    ise_state_t state_r;
    ise_kind_t  kind_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [2:0] blk_r;
    logic       rw_r;
    logic       busy_r;
    logic       byte_done;
    logic       ack_end;
    logic       addr_ok;
    logic       ack_nxt;

    assign byte_done = (state_r == ST_RX) && scl_fall
                       && (cnt_r == `ISE_BYTE_BITS);  // R9
    assign ack_end   = (state_r == ST_ACK) && scl_fall;

    always_comb begin
        addr_ok = (shift_r[7:4] == `ISE_CTRL_CODE)  // R14
                  && blk_ok(shift_r[3:1])  // R14 R23 R26
                  && !(is_ee(shift_r[3:1]) && busy_r);  // R10 R24 R25
        ack_nxt = (kind_r == K_ADDR) ? addr_ok : 1'b1;  // R17
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else if (start_cond) begin
            state_r <= ST_RX;
        end else if (stop_cond) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE, ST_SKIP: begin
                    state_r <= state_r;  // R26
                end
                ST_RX: begin
                    if (byte_done) begin
                        state_r <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (ack_end) begin
                        // Read data phase is served elsewhere
                        if (!sda_oe || (kind_r == K_ADDR && rw_r)) begin
                            state_r <= ST_SKIP;  // R12 R26
                        end else begin
                            state_r <= ST_RX;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Bit counter, shifter and byte kind
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r   <= 4'h0;
            shift_r <= 8'h00;
            kind_r  <= K_ADDR;
        end else if (start_cond) begin
            cnt_r  <= 4'h0;
            kind_r <= K_ADDR;
        end else if (state_r == ST_RX && scl_rise) begin
            shift_r <= {shift_r[6:0], line_r[0]};  // R8 R9
            cnt_r   <= cnt_r + 4'h1;
        end else if (ack_end) begin
            cnt_r  <= 4'h0;
            kind_r <= (kind_r == K_ADDR) ? K_WADDR : K_DATA;  // R17
        end
    end

    // ************************************************************
    // Address byte capture
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            blk_r <= `ISE_BLK_RTC;
            rw_r  <= 1'b0;
        end else if (byte_done && kind_r == K_ADDR && addr_ok) begin
            blk_r <= shift_r[3:1];  // R15
            rw_r  <= shift_r[0] == `ISE_RW_READ;  // R16
        end
    end

    // ************************************************************
    // Word pointer and page buffer
    // ************************************************************
    logic [7:0]                   ptr_r;
    logic [7:0]                   page_buf_r [`ISE_PAGE_BYTES];
    logic [`ISE_PAGE_BYTES-1:0]   mask_r;
    logic                         wrote_r;
    logic [`ISE_PAGE_IDX_W-1:0]   slot;

    assign slot = ptr_r[`ISE_PAGE_IDX_W-1:0];  // R2

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ptr_r <= 8'h00;
        end else if (byte_done && kind_r == K_WADDR) begin
            ptr_r <= shift_r;  // R17
        end else if (byte_done && kind_r == K_DATA) begin
            if (is_ee(blk_r)) begin
                ptr_r <= {ptr_r[7:`ISE_PAGE_IDX_W],
                          slot + 3'h1};  // R3 R20 R21
            end else begin
                ptr_r <= ptr_r + 8'h01;  // R21 R22
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_r  <= '0;
            wrote_r <= 1'b0;
        end else if (start_cond || stop_cond) begin
            mask_r  <= '0;
            wrote_r <= 1'b0;
        end else if (byte_done && kind_r == K_DATA) begin
            mask_r[slot] <= 1'b1;  // R19
            wrote_r      <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `ISE_PAGE_BYTES; i++) begin
                page_buf_r[i] <= 8'h00;
            end
        end else if (byte_done && kind_r == K_DATA && is_ee(blk_r)) begin
            page_buf_r[slot] <= shift_r;  // R19 R20
        end
    end

    // ************************************************************
    // Acknowledge drive, open drain
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sda_oe <= 1'b0;
        end else if (start_cond || stop_cond || ack_end) begin
            sda_oe <= 1'b0;  // R12
        end else if (byte_done) begin
            sda_oe <= ack_nxt;  // R10 R11 R26
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ************************************************************
    // Write cycle launch and busy tracking
    // ************************************************************
    logic ee_go;

    assign ee_go = stop_cond && wrote_r && is_ee(blk_r);  // R18

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
        end else if (ee_go) begin
            busy_r <= 1'b1;  // R18
        end else if (ee_done) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ee_cmd <= '0;
        end else begin
            ee_cmd.valid     <= ee_go;  // R18 R19
            ee_cmd.block_sel <= blk_r;  // R1 R15
            ee_cmd.page      <= ptr_r[7:`ISE_PAGE_IDX_W];
            ee_cmd.mask      <= mask_r;  // R19
            for (int i = 0; i < `ISE_PAGE_BYTES; i++) begin
                ee_cmd.data[i*8 +: 8] <= page_buf_r[i];
            end
        end
    end

    // ************************************************************
    // Clock register writes
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rtc_wr     <= '0;
            rtc_commit <= 1'b0;
        end else begin
            rtc_wr.valid <= byte_done && kind_r == K_DATA
                            && blk_r == `ISE_BLK_RTC;  // R22 R25
            rtc_wr.addr  <= ptr_r;
            rtc_wr.data  <= shift_r;
            rtc_commit   <= stop_cond && wrote_r
                            && blk_r == `ISE_BLK_RTC;  // R22
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ee_busy  <= 1'b0;
            word_ptr <= 8'h00;
        end else begin
            ee_busy  <= busy_r;
            word_ptr <= ptr_r;
        end
    end

endmodule // ise_slave

// ==== include/ise_params.svh ====
`ifndef ISE_PARAMS_SVH
`define ISE_PARAMS_SVH

// ****************************************************************
// Memory organisation
// ****************************************************************
`define ISE_EE_BYTES      512
`define ISE_BLOCK_BYTES   256
`define ISE_BLOCK_PAGES   32
`define ISE_PAGE_BYTES    8
`define ISE_PAGE_IDX_W    3

// ****************************************************************
// Address byte decoding
// ****************************************************************
`define ISE_CTRL_CODE     4'hD
`define ISE_BLK_RTC       3'h0
`define ISE_BLK_EE_LO     3'h1
`define ISE_BLK_EE_HI     3'h2
`define ISE_RW_READ       1'h1
`define ISE_BYTE_BITS     4'h8

// ****************************************************************
// Line sampling
// ****************************************************************
`define ISE_LINE_IDLE     2'h3
`define ISE_SCL_FAST_HZ   400000
`define ISE_MIN_HALF_CYC  4

`endif

// ==== include/ise_pkg.sv ====
package ise_pkg;

    // ************************************************************
    // Receiver states and byte kinds
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_SKIP
    } ise_state_t;

    typedef enum logic [1:0] {
        K_ADDR,
        K_WADDR,
        K_DATA
    } ise_kind_t;

    // ************************************************************
    // Carriers towards the memory and clock cores
    // ************************************************************
    typedef struct packed {
        logic        valid;
        logic [2:0]  block_sel;
        logic [4:0]  page;
        logic [7:0]  mask;
        logic [63:0] data;
    } ise_ee_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } ise_rtc_wr_t;

endpackage

// ==== verif/ise_slave_props.sv ====
`timescale 1ns/1ps
module ise_props
    import ise_pkg::*;
(
    // Clock and reset
    input logic        mclk,
    input logic        rst,
    // Bus pins
    input logic        scl_in,
    input logic        sda_in,
    input logic        sda_out,
    input logic        sda_oe,
    // Cores
    input logic        ee_done,
    input ise_ee_cmd_t ee_cmd,
    input logic        ee_busy,
    input ise_rtc_wr_t rtc_wr,
    input logic        rtc_commit,
    input logic [7:0]  word_ptr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    a_ack_steady: assert property ((sda_oe && scl_in) |=>
        (sda_oe || !scl_in)) else $error("ack dropped in high phase");
    a_cmd_pulse: assert property (ee_cmd.valid |=>
        !ee_cmd.valid [*8]) else $error("ee_cmd.valid too long");
    a_busy_after_cmd: assert property (ee_cmd.valid |->
        ##[1:2] ee_busy) else $error("busy not set after commit");
    a_busy_holds: assert property ((ee_busy && !ee_done &&
        !$past(ee_done)) |=> ee_busy) else $error("busy lost");
    a_busy_clears: assert property ((ee_done && !ee_cmd.valid &&
        !$past(ee_cmd.valid)) |-> ##[1:2] !ee_busy)
        else $error("busy not cleared");
    a_rtc_pulse: assert property (rtc_wr.valid |=> !rtc_wr.valid)
        else $error("rtc_wr.valid too long");
    a_commit_at_stop: assert property ((rtc_commit || ee_cmd.valid)
        |-> (scl_in && sda_in)) else $error("commit outside stop");
    a_ptr_step: assert property (rtc_wr.valid |=>
        (word_ptr == 8'($past(rtc_wr.addr) + 8'h01)))
        else $error("pointer not advanced");
    a_oe_scl_low: assert property ($changed(sda_oe) |->
        !$past(scl_in)) else $error("sda_oe moved while scl high");

    c_ee_commit: cover property (ee_cmd.valid);
    c_rtc_commit: cover property (rtc_commit);
    c_ack_busy: cover property (sda_oe && ee_busy);
endmodule // ise_props

bind ise_slave ise_props u_props (
    .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .ee_done(ee_done),
    .ee_cmd(ee_cmd), .ee_busy(ee_busy), .rtc_wr(rtc_wr),
    .rtc_commit(rtc_commit), .word_ptr(word_ptr)
);

// ==== verif/ise_master_model.sv ====
`timescale 1ns/1ps
module ise_master_model (
    // Bus lines
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_line
);
    localparam int T_LO = 200;
    localparam int T_HI = 120;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Idle or repeated start, skewed off the system clock
    task automatic start_cond();
        #7;
        sda_pull = 1'b0;
        #(T_LO);
        scl = 1'b1;
        #(T_HI * 2);
        sda_pull = 1'b1;
        #(T_HI * 2);
        scl = 1'b0;
    endtask

    task automatic put_bit(input logic b, output logic seen);
        #37;
        sda_pull = ~b;
        #(T_LO - 37);
        scl = 1'b1;
        #100;
        seen = sda_line;
        #(T_HI - 100);
        scl = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic stop_cond();
        #37;
        sda_pull = 1'b1;
        #(T_LO - 37);
        scl = 1'b1;
        #(T_HI * 2);
        sda_pull = 1'b0;
        #(T_HI * 2);
    endtask
endmodule // ise_master_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import ise_pkg::*;
;
    logic        mclk;
    logic        rst;
    logic        scl;
    logic        sda_pull;
    logic        ee_done;
    wire logic   sda_line;
    logic        sda_out;
    logic        sda_oe;
    logic        ee_busy;
    logic        rtc_commit;
    logic [7:0]  word_ptr;
    ise_ee_cmd_t ee_cmd;
    ise_rtc_wr_t rtc_wr;
    ise_ee_cmd_t q_ee[$];
    ise_rtc_wr_t q_rtc[$];
    int          n_mismatch;
    int          checked;
    int          n_commit;
    logic [8:0]  adr_tbl[7] = '{9'h1D2, 9'h1D4, 9'h1D0, 9'h0D6, 9'h0D8,
                                9'h0A2, 9'h1D3};

    // Open-drain wire with pull-up
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

    ise_slave #(.MCLK_HZ(25000000)) u_dut (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .ee_done(ee_done),
        .ee_cmd(ee_cmd), .ee_busy(ee_busy), .rtc_wr(rtc_wr),
        .rtc_commit(rtc_commit), .word_ptr(word_ptr)
    );
    ise_master_model u_mst (
        .scl(scl), .sda_pull(sda_pull), .sda_line(sda_line)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [81:0] seen,
                         input logic [81:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic ack;
        u_mst.put_byte(d, ack);
        check("ack", 82'(ack), 82'(exp_ack));
    endtask

    task automatic poll(input logic [7:0] adr, input logic exp_ack);
        u_mst.start_cond();
        send(adr, exp_ack);
    endtask

    task automatic end_cycle();
        @(posedge mclk);
        ee_done <= 1'b1;
        @(posedge mclk);
        ee_done <= 1'b0;
        repeat (3) @(posedge mclk);
        check("ee_busy", 82'(ee_busy), 82'(1'b0));
    endtask

    task automatic ee_page(input logic [7:0] adr, input logic [7:0] wa,
                           input int n);
        ise_ee_cmd_t e;
        logic [7:0]  d;
        logic [2:0]  slot;
        e = '0;
        e.valid = 1'b1;
        e.block_sel = adr[3:1];
        e.page = wa[7:3];
        slot = wa[2:0];
        poll(adr, 1'b1);
        send(wa, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            send(d, 1'b1);
            e.data[8*slot +: 8] = d;
            e.mask[slot] = 1'b1;
            slot = slot + 3'h1;
        end
        q_ee.push_back(e);
        u_mst.stop_cond();
        check("word_ptr", 82'(word_ptr), 82'({wa[7:3], slot}));
    endtask

    task automatic rtc_write(input logic [7:0] wa, input int n);
        ise_rtc_wr_t r;
        r.valid = 1'b1;
        r.addr = wa;
        poll(8'hD0, 1'b1);
        send(wa, 1'b1);
        for (int i = 0; i < n; i++) begin
            r.data = 8'($urandom);
            q_rtc.push_back(r);
            send(r.data, 1'b1);
            r.addr = r.addr + 8'h01;
        end
        u_mst.stop_cond();
    endtask

    // ************************************************************
    // Result monitor
    // ************************************************************
    always @(posedge mclk) begin : mon
        ise_ee_cmd_t e;
        ise_ee_cmd_t s;
        if (rtc_commit !== 1'b0) n_commit++;
        if (ee_cmd.valid !== 1'b0) begin
            e = (q_ee.size() > 0) ? q_ee.pop_front() : '0;
            s = ee_cmd;
            for (int i = 0; i < 8; i++) begin
                if (e.mask[i] !== 1'b1) begin
                    s.data[8*i +: 8] = 8'h00;
                    e.data[8*i +: 8] = 8'h00;
                end
            end
            check("ee_cmd", 82'(s), 82'(e));
        end
        if (rtc_wr.valid !== 1'b0) begin
            check("rtc_wr", 82'(rtc_wr),
                  82'((q_rtc.size() > 0) ? q_rtc.pop_front() : '0));
        end
    end

    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        ee_done = 1'b0;
        n_mismatch = 0;
        checked = 0;
        n_commit = 0;
        void'($urandom(32'hddfd6971));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        foreach (adr_tbl[i]) begin
            poll(adr_tbl[i][7:0], adr_tbl[i][8]);
            if (adr_tbl[i][8] !== 1'b1) send(8'($urandom), 1'b0);
        end
        u_mst.stop_cond();
        poll(8'hD4, 1'b1);
        send(8'h17, 1'b1);
        send(8'($urandom), 1'b1);
        ee_page(8'hD4, 8'h10, 3);
        repeat (3) @(posedge mclk);
        check("ee_busy", 82'(ee_busy), 82'(1'b1));
        poll(8'hD2, 1'b0);
        poll(8'hD0, 1'b1);
        u_mst.stop_cond();
        end_cycle();
        poll(8'hD2, 1'b1);
        ee_page(8'hD2, 8'h0D, 10);
        rtc_write(8'hFE, 3);
        end_cycle();
        repeat (10) @(posedge mclk);
        check("n_commit", 82'(n_commit), 82'(1));
        check("queued", 82'(q_ee.size() + q_rtc.size()), 82'(0));
        report_and_stop();
    end
endmodule // tb_top
